// [rtl/spa_arb_if.sv]
/*
 Carrier between the pin mux top and its round-robin arbiter.
 Assumes one clock domain; no clocking block.
*/
`timescale 1ns/1ps
`include "spa_params.svh"

interface spa_arb_if;
    spa_pkg::spa_vec_t req;
    spa_pkg::spa_vec_t gnt;
    spa_pkg::spa_idx_t owner;
    logic busy;

    modport arbiter (
        input req,
        output gnt,
        output owner,
        output busy
    );
    modport user (
        output req,
        input gnt,
        input owner,
        input busy
    );
endinterface

// [rtl/spa_params.svh]
/*
 Constants of the shared pin arbiter: port count, role widths, reset values.
 Assumes inclusion by the package and the design files, bare name.
*/
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH

// number of controller ports attached
`define SPA_PORT_COUNT 2
`define SPA_IDX_W 1

// shared role widths (downstream width is the widest port)
`define SPA_ADDR_W 18
`define SPA_DATA_W 16
`define SPA_CTL_W 2
`define SPA_IRQ_W 1

// per port widths of the shared roles, packed 8 bits per port
`define SPA_ADDR_W_LIST 16'h1012
`define SPA_DATA_W_LIST 16'h0810

// reset values
`define SPA_EN_RESET 1'b0
`define SPA_GRANT_RESET 1'b0

`endif

// [rtl/spa_pin_mux.sv]
/*
 Pin sharing mux: several memory controllers share one pin bridge port.
 Assumes controllers and bridge run on clk; bridge registers the pads.
 Shared roles: address (output), data (bidirectional), control (tri-state
 output), interrupt (input). Port 0 keeps a private chip select and port 1
 a private interrupt input, both unshared.
*/
`timescale 1ns/1ps
`include "spa_params.svh"

// Summary of operation
// - at most one granted port drives the shared downstream pins; none while idle
// - grants rotate round-robin over requesting ports
// - granted port's values and enables appear at the bridge
// - same-role signals merge onto one downstream signal, fixed at build
// - each signal is a drive value, a drive enable or an input
// - bidirectional role has out, enable and in signals
// - tri-state output role has out and enable only
// - tri-state enables are off while reset is active
// - plain output has value only; plain input has value only
// - narrower port signals align at bit zero
// - bits above a granted narrow port's width read zero
// - unshared signals pass straight through
// - port count is a build-time constant setting port pairs
// - all drive enables are off during reset
// - grant holds until one cycle after request falls
// - no port gets a new grant when no port requests
module spa_pin_mux (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic [`SPA_PORT_COUNT-1:0] req, // per port request
    output logic [`SPA_PORT_COUNT-1:0] gnt, // per port grant
    // upstream shared roles, one lane per port
    input wire logic [`SPA_PORT_COUNT*`SPA_ADDR_W-1:0] up_addr_out, // addr
    input wire logic [`SPA_PORT_COUNT*`SPA_DATA_W-1:0] up_data_out, // data
    input wire logic [`SPA_PORT_COUNT-1:0] up_data_outen, // data enable
    output logic [`SPA_DATA_W-1:0] up_data_in, // data seen at pins
    input wire logic [`SPA_PORT_COUNT*`SPA_CTL_W-1:0] up_ctl_out, // control
    input wire logic [`SPA_PORT_COUNT-1:0] up_ctl_outen, // control enable
    output logic [`SPA_IRQ_W-1:0] up_irq_in, // shared interrupt seen
    // unshared signals
    input wire logic up0_cs_out, // port 0 private chip select
    output logic dn_cs_out, // private chip select to bridge
    input wire logic dn_aux_in, // private input from bridge
    output logic up1_aux_in, // private input to port 1
    // downstream bridge port
    output logic [`SPA_ADDR_W-1:0] dn_addr_out, // shared address
    output logic [`SPA_DATA_W-1:0] dn_data_out, // shared data value
    output logic dn_data_outen, // data enable, high drives
    input wire logic [`SPA_DATA_W-1:0] dn_data_in, // data from bridge
    output logic [`SPA_CTL_W-1:0] dn_ctl_out, // shared control value
    output logic dn_ctl_outen, // control enable, high drives
    input wire logic [`SPA_IRQ_W-1:0] dn_irq_in // interrupt from bridge
);
    localparam int N = `SPA_PORT_COUNT;
    localparam logic [15:0] ADDR_WL = `SPA_ADDR_W_LIST;
    localparam logic [15:0] DATA_WL = `SPA_DATA_W_LIST;

    spa_arb_if arb ();

    spa_rr_arbiter u_arb (
        .clk(clk),
        .rst(rst),
        .arb(arb.arbiter)
    );

    assign arb.req = req;
    assign gnt = arb.gnt;

    // *****************************************************************
    // width masks
    // *****************************************************************
    // build-time lane width becomes a low-bit mask
    function automatic logic [`SPA_DATA_W-1:0] data_mask(input int w);
        logic [`SPA_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `SPA_DATA_W; i++) begin
            if (i < w) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [`SPA_ADDR_W-1:0] addr_mask(input int w);
        logic [`SPA_ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < `SPA_ADDR_W; i++) begin
            if (i < w) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // *****************************************************************
    // per port lanes, masked to the port's own width
    // *****************************************************************
    logic [`SPA_ADDR_W-1:0] addr_lane [N];
    logic [`SPA_DATA_W-1:0] data_lane [N];
    logic [`SPA_CTL_W-1:0] ctl_lane [N];

    genvar p;
    generate
        for (p = 0; p < N; p++) begin : gen_lane
            localparam int AW = int'(ADDR_WL[8*p +: 8]);
            localparam int DW = int'(DATA_WL[8*p +: 8]);
            // zero above the lane width, aligned at bit zero
            assign addr_lane[p] = up_addr_out[p*`SPA_ADDR_W +: `SPA_ADDR_W]
                                  & addr_mask(AW);
            assign data_lane[p] = up_data_out[p*`SPA_DATA_W +: `SPA_DATA_W]
                                  & data_mask(DW);
            assign ctl_lane[p] = up_ctl_out[p*`SPA_CTL_W +: `SPA_CTL_W];
        end
    endgenerate

    // *****************************************************************
    // selection of the granted port
    // *****************************************************************
    wire spa_pkg::spa_idx_t sel = arb.owner;
    wire owned = arb.busy;
    wire [`SPA_ADDR_W-1:0] addr_sel = addr_lane[sel];
    wire [`SPA_DATA_W-1:0] data_sel = data_lane[sel];
    wire [`SPA_CTL_W-1:0] ctl_sel = ctl_lane[sel];
    // no owner means nobody drives: enables forced off
    wire data_en_sel = owned & up_data_outen[sel];
    wire ctl_en_sel = owned & up_ctl_outen[sel];

    // *****************************************************************
    // downstream registers
    // *****************************************************************
    // registered so pins change only on clock edges; costs one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dn_addr_out <= '0;
            dn_data_out <= '0;
            dn_ctl_out <= '0;
        end else begin
            dn_addr_out <= owned ? addr_sel : '0;
            dn_data_out <= owned ? data_sel : '0;
            dn_ctl_out <= owned ? ctl_sel : '0;
        end
    end

    // enables held off through reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dn_data_outen <= `SPA_EN_RESET;
            dn_ctl_outen <= `SPA_EN_RESET;
        end else begin
            dn_data_outen <= data_en_sel;
            dn_ctl_outen <= ctl_en_sel;
        end
    end

    // unshared output, straight through at the same latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dn_cs_out <= 1'b0;
        end else begin
            dn_cs_out <= up0_cs_out;
        end
    end

    // *****************************************************************
    // inputs fanned out to every port; the private input goes to port 1 only
    // *****************************************************************
    // bridge already registers the pads, so one stage here suffices
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_data_in <= '0;
            up_irq_in <= '0;
            up1_aux_in <= 1'b0;
        end else begin
            up_data_in <= dn_data_in;
            up_irq_in <= dn_irq_in;
            up1_aux_in <= dn_aux_in;
        end
    end
endmodule

// [rtl/spa_pkg.sv]
/*
 Types shared by the pin arbiter modules.
 Assumes spa_params.svh is on the include path.
*/
`include "spa_params.svh"

package spa_pkg;
    typedef enum logic [1:0] {
        SPA_IDLE,
        SPA_BUSY
    } spa_state_t;

    typedef logic [`SPA_PORT_COUNT-1:0] spa_vec_t;
    typedef logic [`SPA_IDX_W-1:0] spa_idx_t;
endpackage

// [rtl/spa_rr_arbiter.sv]
/*
 Round-robin arbiter with hold-until-release grants.
 Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "spa_params.svh"

module spa_rr_arbiter (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    spa_arb_if.arbiter arb // request, grant and owner
);
    localparam int N = `SPA_PORT_COUNT;

    spa_pkg::spa_state_t state_r;
    spa_pkg::spa_state_t state_nxt;
    spa_pkg::spa_idx_t owner_r;
    spa_pkg::spa_idx_t owner_nxt;
    spa_pkg::spa_idx_t last_r;
    spa_pkg::spa_idx_t last_nxt;
    spa_pkg::spa_idx_t pick;
    logic any_req;
    logic owner_req;

    // *****************************************************************
    // rotating choice
    // *****************************************************************
    // first requester after the last owner wins
    function automatic spa_pkg::spa_idx_t next_owner(
        input spa_pkg::spa_vec_t req,
        input spa_pkg::spa_idx_t last
    );
        spa_pkg::spa_idx_t sel;
        int k;
        sel = last;
        for (int i = N; i >= 1; i--) begin
            k = (int'(last) + i) % N;
            if (req[k]) begin
                sel = spa_pkg::spa_idx_t'(k);
            end
        end
        return sel;
    endfunction

    assign any_req = |arb.req;
    assign pick = next_owner(arb.req, last_r);
    assign owner_req = arb.req[owner_r];

    // *****************************************************************
    // grant sequencing
    // *****************************************************************
    always_comb begin
        state_nxt = state_r;
        owner_nxt = owner_r;
        last_nxt = last_r;
        case (state_r)
            spa_pkg::SPA_IDLE: begin
                // no default owner while nobody asks
                if (any_req) begin
                    state_nxt = spa_pkg::SPA_BUSY;
                    owner_nxt = pick;
                    last_nxt = pick;
                end
            end
            spa_pkg::SPA_BUSY: begin
                // request low in this cycle marks the final granted cycle
                if (!owner_req) begin
                    state_nxt = spa_pkg::SPA_IDLE;
                end
            end
            default: begin
                state_nxt = spa_pkg::SPA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= spa_pkg::SPA_IDLE;
            owner_r <= '0;
            last_r <= spa_pkg::spa_idx_t'(N - 1);
        end else begin
            state_r <= state_nxt;
            owner_r <= owner_nxt;
            last_r <= last_nxt;
        end
    end

    // *****************************************************************
    // grant outputs
    // *****************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_gnt
            assign arb.gnt[g] = (state_r == spa_pkg::SPA_BUSY) &&
                                (owner_r == spa_pkg::spa_idx_t'(g));
        end
    endgenerate

    assign arb.owner = owner_r;
    assign arb.busy = (state_r == spa_pkg::SPA_BUSY);
endmodule

// [testbench/spa_bridge_model.sv]
/* Pad bridge model: registers pad values back to the mux.
 Assumes the mux drives it on the same clock. */
`timescale 1ns/1ps
// ******
// bridge
// ******
module spa_bridge_model (
    input wire logic clk, // clock
    input wire logic [15:0] data_out, // pad drive
    input wire logic data_outen, // high drives
    output logic [15:0] data_in, // pad seen
    output logic [0:0] irq_in, // interrupt pad
    output logic aux_in // private pad
);
    logic [15:0] cnt;
    initial begin
        cnt = 16'h0;
        data_in = 16'h0;
        irq_in = 1'h0;
        aux_in = 1'h0;
    end
    always @(posedge clk) begin
        cnt <= cnt + 16'h1;
        // no pull on the pads: undriven shows a moving pattern
        data_in <= data_outen ? data_out : cnt ^ 16'h5A5A;
        irq_in <= cnt[2:2];
        aux_in <= cnt[1];
    end
endmodule

// [testbench/spa_pin_mux_checker.sv]
/* Assertions on the pin mux top ports.
 Assumes it is bound to spa_pin_mux, one clock domain. */
`timescale 1ns/1ps
// ******
// checker
// ******
module spa_pin_mux_checker (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic [1:0] req, // requests
    input wire logic [1:0] gnt, // grants
    input wire logic [35:0] up_addr_out, // addr lanes
    input wire logic [31:0] up_data_out, // data lanes
    input wire logic [1:0] up_data_outen, // data enables
    input wire logic [15:0] up_data_in, // data fanout
    input wire logic up0_cs_out, // cs in
    input wire logic dn_cs_out, // cs out
    input wire logic dn_aux_in, // aux in
    input wire logic up1_aux_in, // aux out
    input wire logic [17:0] dn_addr_out, // addr
    input wire logic [15:0] dn_data_out, // data
    input wire logic dn_data_outen, // data en
    input wire logic [15:0] dn_data_in, // pad data
    input wire logic dn_ctl_outen // ctl en
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // owner has dropped its request: its last granted cycle
    sequence s_final;
        gnt != 2'h0 && (gnt & req) == 2'h0;
    endsequence
    // disable iff sees rst already low on the release edge, where the
    // arbiter is still held; a request kept through reset is served
    // one edge later
    sequence s_waiting;
        !rst && gnt == 2'h0 && req != 2'h0;
    endsequence
    chk_one_owner: assert property ($onehot0(gnt))
        else $error("more than one grant");
    chk_no_default: assert property (req == 2'h0 && gnt == 2'h0 |=>
        gnt == 2'h0) else $error("grant with no request");
    chk_grant_hold: assert property ((gnt & req) != 2'h0 |=>
        gnt == $past(gnt)) else $error("grant lost early");
    chk_grant_end: assert property (s_final |=> gnt == 2'h0)
        else $error("grant held too long");
    chk_grant_soon: assert property (s_waiting |=> gnt != 2'h0)
        else $error("request left waiting");
    chk_rr_turn: assert property (s_waiting ##0 req == 2'h3 &&
        $past(gnt) == 2'h1 |=> gnt == 2'h2) else $error("no rotation");
    chk_wide_lane: assert property ($past(gnt) == 2'h1 |->
        dn_addr_out == $past(up_addr_out[17:0]) &&
        dn_data_out == $past(up_data_out[15:0]) &&
        dn_data_outen == $past(up_data_outen[0]))
        else $error("port 0 lane not routed");
    chk_narrow_lane: assert property ($past(gnt) == 2'h2 |->
        dn_addr_out == {2'h0, $past(up_addr_out[33:18])} &&
        dn_data_out == {8'h00, $past(up_data_out[23:16])})
        else $error("port 1 lane not aligned");
    chk_idle_off: assert property ($past(gnt) == 2'h0 |->
        !dn_data_outen && !dn_ctl_outen) else $error("idle enable on");
    chk_in_fanout: assert property (!$past(rst) |->
        up_data_in == $past(dn_data_in)) else $error("input not fanned");
    chk_pass_thru: assert property (!$past(rst) |->
        dn_cs_out == $past(up0_cs_out) && up1_aux_in == $past(dn_aux_in))
        else $error("private pin not passed");
endmodule
bind spa_pin_mux spa_pin_mux_checker chk (.clk, .rst, .req, .gnt,
    .up_addr_out, .up_data_out, .up_data_outen, .up_data_in, .up0_cs_out,
    .dn_cs_out, .dn_aux_in, .up1_aux_in, .dn_addr_out, .dn_data_out,
    .dn_data_outen, .dn_data_in, .dn_ctl_outen);

// [testbench/spa_pin_mux_tb_top.sv]
/* Self-checking bench for the pin mux, bench acts as both controllers.
 Assumes the bridge model and the bound checker. */
`timescale 1ns/1ps
// ******
// bench
// ******
module spa_pin_mux_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] req = 2'h0, gnt, up_data_outen = 2'h0, up_ctl_outen = 2'h0;
    logic [35:0] up_addr_out = 36'h0;
    logic [31:0] up_data_out = 32'h0;
    logic [3:0] up_ctl_out = 4'h0;
    logic up0_cs_out = 1'b0, dn_cs_out, dn_aux_in, up1_aux_in;
    logic [15:0] up_data_in, dn_data_out, dn_data_in;
    logic [17:0] dn_addr_out;
    logic [1:0] dn_ctl_out;
    logic [0:0] up_irq_in, dn_irq_in;
    logic dn_data_outen, dn_ctl_outen;
    // reference arbiter: pointer holds the last owner
    logic busy = 1'b0, owner = 1'b0, last = 1'b1;
    int err_count = 0, total_checks = 0, cycles = 0, n = 0;
    always #2 clk = ~clk;
    spa_pin_mux dut (.clk, .rst, .req, .gnt, .up_addr_out, .up_data_out,
        .up_data_outen, .up_data_in, .up_ctl_out, .up_ctl_outen,
        .up_irq_in, .up0_cs_out, .dn_cs_out, .dn_aux_in, .up1_aux_in,
        .dn_addr_out, .dn_data_out, .dn_data_outen, .dn_data_in,
        .dn_ctl_out, .dn_ctl_outen, .dn_irq_in);
    spa_bridge_model bridge (.clk, .data_out(dn_data_out),
        .data_outen(dn_data_outen), .data_in(dn_data_in),
        .irq_in(dn_irq_in), .aux_in(dn_aux_in));
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one cycle: predict registered outputs, drive r, judge at negedge
    task automatic step(input logic [1:0] r);
        logic [1:0] eg;
        logic [17:0] ea, v;
        logic [15:0] ed;
        logic [3:0] em;
        logic [18:0] ep;
        @(posedge clk);
        eg = busy ? (owner ? 2'h2 : 2'h1) : 2'h0;
        ea = eg[0] ? up_addr_out[17:0] : {2'h0, up_addr_out[33:18]};
        ed = eg[0] ? up_data_out[15:0] : {8'h00, up_data_out[23:16]};
        em = {|(eg & up_data_outen), |(eg & up_ctl_outen),
            eg[0] ? up_ctl_out[1:0] : up_ctl_out[3:2]};
        ep = {dn_data_in, dn_irq_in, up0_cs_out, dn_aux_in};
        if (eg == 2'h0) begin
            ea = 18'h0;
            ed = 16'h0;
            em = 4'h0;
        end
        if (busy && !req[owner]) begin
            busy = 1'b0;
        end else if (!busy && req != 2'h0) begin
            owner = req[~last] ? ~last : last;
            last = owner;
            busy = 1'b1;
        end
        n++;
        v = 18'(n) * 18'h25;
        req <= r;
        up_addr_out <= {~v, v};
        up_data_out <= {~v[15:0], v[15:0]};
        up_data_outen <= v[1:0];
        up_ctl_outen <= v[2:1];
        up_ctl_out <= v[3:0];
        up0_cs_out <= v[0];
        @(negedge clk);
        check(gnt, busy ? (owner ? 2'h2 : 2'h1) : 2'h0);
        check(dn_addr_out, ea);
        check(dn_data_out, ed);
        check({dn_data_outen, dn_ctl_outen, dn_ctl_out}, em);
        check({up_data_in, up_irq_in, dn_cs_out, up1_aux_in}, ep);
    endtask
    task automatic run(input logic [1:0] v[$]);
        foreach (v[i]) step(v[i]);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        busy = 1'b0;
        last = 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check({gnt, dn_data_outen, dn_ctl_outen}, 4'h0);
        @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic sc_idle;
        run('{0, 0, 0});
    endtask
    // short access, instant re-request, then a longer narrow access
    task automatic sc_single;
        run('{1, 0, 1, 1, 0, 2, 2, 2, 0, 0});
    endtask
    // both request: port 1 must win after port 0
    task automatic sc_contend;
        run('{3, 2, 3, 3, 1, 1, 0, 0});
    endtask
    // reset in mid access, pointer restarts at port 1 so port 0 wins first
    task automatic sc_reset_mid;
        run('{3, 3});
        do_reset();
        run('{3, 2, 2, 0, 0});
    endtask
    initial begin
        do_reset();
        sc_idle();
        sc_single();
        sc_contend();
        sc_reset_mid();
        give_verdict();
    end
endmodule
